// [dv/fractional_sample_interpolator_tb.sv]
/*
  fractional_sample_interpolator_tb: self-checking bench.
  Assumes latency 2 from the request cycle and a one-cycle valid.
*/
`timescale 1ns/1ps
module fractional_sample_interpolator_tb;
  import fsi_pkg::*;
  logic clock = 1'b0;
  logic srst = 1'b1;
  logic req_valid = 1'b0;
  logic req_eighth = 1'b0;
  logic req_chroma = 1'b0;
  logic [3:0] frac_x = 4'h0;
  logic [3:0] frac_y = 4'h0;
  logic st_load = 1'b0;
  logic [1:0] st_mode = 2'h0;
  logic [7:0] st_base = 8'h00;
  logic [7:0] ref_win [0:7][0:7];
  logic out_valid;
  logic [7:0] out_sample;
  int n_fail = 0;
  int samples_checked = 0;
  int cyc = 0;
  int due_q [$];
  logic [7:0] exp_q [$];

  // 25 MHz clock and cycle count
  always #20 clock = ~clock;
  always @(posedge clock) cyc <= cyc + 1;

  fsi_store_model u_store (.clock(clock), .load(st_load), .mode(st_mode),
    .base(st_base), .present(req_valid), .ref_win(ref_win));

  fsi_interp u_dut (.clock(clock), .srst(srst), .req_valid(req_valid),
    .req_eighth(req_eighth), .req_chroma(req_chroma), .frac_x(frac_x),
    .frac_y(frac_y), .ref_win(ref_win), .out_valid(out_valid),
    .out_sample(out_sample));

  task automatic compare_flag(logic got, logic exp);
    samples_checked++;
    if (got !== exp) begin
      n_fail++;
      $display("unexpected flag at %0t: got %h expected %h", $time, got, exp);
    end
  endtask

  task automatic compare_sample(logic [7:0] got, logic [7:0] exp);
    samples_checked++;
    if (got !== exp) begin
      n_fail++;
      $display("unexpected sample at %0t: got %h expected %h", $time, got, exp);
    end
  endtask

  task automatic results();
    $display("comparisons %0d, mismatches %0d", samples_checked, n_fail);
    if (n_fail == 0 && samples_checked > 0) begin
      $display("Testbench passed");
    end else begin
      $display("Testbench failed");
    end
    $finish;
  endtask

  // reference arithmetic over the stored window
  function automatic int px(int r, int c);
    return int'(u_store.win_reg[r][c]);
  endfunction
  function automatic int clamp8(int v);
    return (v < 0) ? 0 : ((v > 255) ? 255 : v);
  endfunction
  function automatic int f6(logic h, int i);
    int s = 0;
    for (int k = 0; k < 6; k++) s += int'(FSI_TAP6[k]) * (h ? px(i, k + 1) : px(k + 1, i));
    return s;
  endfunction
  function automatic int f8(logic h, int i, int t);
    int s = 0;
    for (int k = 0; k < 8; k++) s += int'(FSI_TAP8[t][k]) * (h ? px(i, k) : px(k, i));
    return s;
  endfunction
  function automatic int q_b(logic h);
    return clamp8((f6(h, 3) + 16) >>> 5);
  endfunction
  function automatic int q_c();
    int s = 0;
    for (int k = 0; k < 6; k++) s += int'(FSI_TAP6[k]) * f6(1'b1, k + 1);
    return clamp8((s + 512) >>> 10);
  endfunction
  function automatic int e_b(logic h, int t);
    return clamp8((f8(h, 3, t) + 128) >>> 8);
  endfunction
  function automatic int e_c(int tx, int ty);
    int s = 0;
    for (int k = 0; k < 8; k++) s += int'(FSI_TAP8[ty][k]) * f8(1'b1, k, tx);
    return clamp8((s + 32768) >>> 16);
  endfunction
  function automatic int chroma(logic e, logic [3:0] fx, logic [3:0] fy);
    int s = e ? 16 : 8;
    int dx = e ? int'(fx) : int'(fx[2:0]);
    int dy = e ? int'(fy) : int'(fy[2:0]);
    return ((s - dx) * (s - dy) * px(3, 3) + dx * (s - dy) * px(3, 4)
      + (s - dx) * dy * px(4, 3) + dx * dy * px(4, 4) + s * s / 2) / (s * s);
  endfunction

  // results are judged here; any cycle without a due result must be quiet
  always @(posedge clock) begin
    #1;
    if (!srst) begin
      if (due_q.size() > 0 && due_q[0] == cyc) begin
        compare_flag(out_valid, 1'b1);
        compare_sample(out_sample, exp_q.pop_front());
        due_q.delete(0);
      end else begin
        compare_flag(out_valid, 1'b0);
      end
    end
  end

  task automatic load(logic [1:0] m, logic [7:0] b);
    @(posedge clock);
    st_load <= 1'b1;
    st_mode <= m;
    st_base <= b;
    @(posedge clock);
    st_load <= 1'b0;
    @(posedge clock);
  endtask

  // back-to-back capable: request holds until the next call or drain
  task automatic send(logic e, logic ch, logic [3:0] fx, logic [3:0] fy, int v);
    @(posedge clock);
    req_valid <= 1'b1;
    req_eighth <= e;
    req_chroma <= ch;
    frac_x <= fx;
    frac_y <= fy;
    due_q.push_back(cyc + 3);
    exp_q.push_back(8'(v));
  endtask

  task automatic drain();
    int k = 0;
    @(posedge clock);
    req_valid <= 1'b0;
    while (due_q.size() > 0 && k < 8) begin
      @(posedge clock);
      #2;
      k++;
    end
    // results still owed after the limit count as a mismatch
    if (due_q.size() > 0) begin
      n_fail++;
      $display("unexpected pending results at %0t: got %h expected %h", $time,
        due_q.size(), 0);
      due_q.delete();
      exp_q.delete();
    end
  endtask

  task automatic t_reset();
    #2;
    compare_flag(out_valid, 1'b0);
    compare_sample(out_sample, FSI_OUT_RST);
  endtask

  task automatic t_integer();
    load(2'h0, 8'h21);
    send(1'b0, 1'b0, 4'h0, 4'h0, px(3, 3));
    send(1'b1, 1'b0, 4'h8, 4'h8, px(3, 3));
    send(1'b0, 1'b1, 4'h0, 4'h0, px(3, 3));
    drain();
  endtask

  task automatic t_quarter();
    load(2'h0, 8'h05);
    send(1'b0, 1'b0, 4'hE, 4'h0, q_b(1'b1));
    send(1'b0, 1'b0, 4'h0, 4'h2, q_b(1'b0));
    send(1'b0, 1'b0, 4'h2, 4'h2, q_c());
    send(1'b0, 1'b0, 4'h1, 4'h0, (px(3, 3) + q_b(1'b1)) >> 1);
    send(1'b0, 1'b0, 4'h3, 4'h0, (q_b(1'b1) + px(3, 4)) >> 1);
    send(1'b0, 1'b0, 4'h0, 4'h1, (px(3, 3) + q_b(1'b0)) >> 1);
    send(1'b0, 1'b0, 4'h1, 4'h1, (q_b(1'b1) + q_b(1'b0)) >> 1);
    send(1'b0, 1'b0, 4'h2, 4'h1, (q_b(1'b1) + q_c()) >> 1);
    send(1'b0, 1'b0, 4'h3, 4'h3, (px(3, 3) + px(3, 4) + px(4, 3) + px(4, 4) + 2) >> 2);
    drain();
  endtask

  task automatic t_eighth();
    load(2'h0, 8'hC8);
    send(1'b1, 1'b0, 4'h2, 4'h0, e_b(1'b1, 1));
    send(1'b1, 1'b0, 4'h4, 4'h0, e_b(1'b1, 2));
    send(1'b1, 1'b0, 4'h6, 4'h0, e_b(1'b1, 3));
    send(1'b1, 1'b0, 4'h0, 4'h4, e_b(1'b0, 2));
    send(1'b1, 1'b0, 4'h4, 4'h4, e_c(2, 2));
    send(1'b1, 1'b0, 4'h2, 4'h6, e_c(1, 3));
    send(1'b1, 1'b0, 4'h1, 4'h0, (px(3, 3) + e_b(1'b1, 1)) >> 1);
    send(1'b1, 1'b0, 4'h1, 4'h1, (e_b(1'b1, 1) + e_b(1'b0, 1)) >> 1);
    send(1'b1, 1'b0, 4'h3, 4'h3, (px(3, 3) + 3 * e_c(2, 2) + 2) >> 2);
    send(1'b1, 1'b0, 4'h3, 4'h1, (3 * e_b(1'b1, 2) + e_c(1, 1) + 2) >> 2);
    send(1'b1, 1'b0, 4'h1, 4'h3, (3 * e_b(1'b0, 2) + e_c(1, 1) + 2) >> 2);
    drain();
  endtask

  task automatic t_chroma();
    load(2'h0, 8'h3A);
    send(1'b0, 1'b1, 4'hB, 4'h5, chroma(1'b0, 4'hB, 4'h5));
    send(1'b0, 1'b1, 4'h7, 4'h7, chroma(1'b0, 4'h7, 4'h7));
    send(1'b1, 1'b1, 4'h9, 4'h4, chroma(1'b1, 4'h9, 4'h4));
    send(1'b1, 1'b1, 4'hF, 4'hF, chroma(1'b1, 4'hF, 4'hF));
    send(1'b0, 1'b1, 4'h4, 4'h0, chroma(1'b0, 4'h4, 4'h0));
    send(1'b1, 1'b1, 4'h8, 4'h0, chroma(1'b1, 4'h8, 4'h0));
    drain();
  endtask

  // a flat area must come back unchanged at four luma positions, two quarter and two eighth
  task automatic t_flat();
    load(2'h3, 8'h5A);
    send(1'b0, 1'b0, 4'h2, 4'h2, 8'h5A);
    send(1'b0, 1'b0, 4'h1, 4'h3, 8'h5A);
    send(1'b1, 1'b0, 4'h3, 4'h5, 8'h5A);
    send(1'b1, 1'b0, 4'h5, 4'h7, 8'h5A);
    drain();
  endtask

  task automatic t_clamp();
    load(2'h1, 8'h00);
    send(1'b0, 1'b0, 4'h2, 4'h0, 8'hFF);
    send(1'b1, 1'b0, 4'h4, 4'h0, 8'hFF);
    send(1'b0, 1'b0, 4'h2, 4'h2, q_c());
    drain();
    load(2'h2, 8'h00);
    send(1'b0, 1'b0, 4'h2, 4'h0, 8'h00);
    send(1'b1, 1'b0, 4'h4, 4'h0, 8'h00);
    send(1'b1, 1'b0, 4'h4, 4'h4, e_c(2, 2));
    drain();
  endtask

  // main sequence: reset for 12 cycles, then the scenarios
  initial begin
    repeat (12) @(posedge clock);
    srst <= 1'b0;
    t_reset();
    t_integer();
    t_quarter();
    t_eighth();
    t_chroma();
    t_clamp();
    t_flat();
    results();
  end

  // the run needs under a hundred cycles; over thirty times that means a hang
  initial begin
    repeat (3000) @(posedge clock);
    n_fail++;
    $display("unexpected timeout at %0t: got %h expected %h", $time, cyc, 0);
    results();
  end
endmodule

// [dv/fsi_store_model.sv]
/*
  fsi_store_model: reference store holding one 8x8 window.
  Assumes the bench loads a pattern before requesting and
  raises present while a request is on the window.
*/
`timescale 1ns/1ps
module fsi_store_model (
  // clock
  input wire logic clock,
  // pattern load from the bench
  input wire logic load,
  input wire logic [1:0] mode,
  input wire logic [7:0] base,
  input wire logic present,
  // window toward the interpolator
  output logic [7:0] ref_win [0:7][0:7]
);
  logic [7:0] win_reg [0:7][0:7];

  // ramp, bright or dark middle columns, or a flat area
  always_ff @(posedge clock) begin
    if (load) begin
      for (int r = 0; r < 8; r++) begin
        for (int c = 0; c < 8; c++) begin
          case (mode)
            2'h1: win_reg[r][c] <= (c == 3 || c == 4) ? 8'hFF : 8'h00;
            2'h2: win_reg[r][c] <= (c == 3 || c == 4) ? 8'h00 : 8'hFF;
            2'h3: win_reg[r][c] <= base;
            default: win_reg[r][c] <= base + 8'(r * 17) + 8'(c * 29);
          endcase
        end
      end
    end
  end

  // whole support shown with the request; inverse otherwise so stale
  // data can never pass for a match
  always_comb begin
    for (int r = 0; r < 8; r++) begin
      for (int c = 0; c < 8; c++) begin
        ref_win[r][c] = present ? win_reg[r][c] : ~win_reg[r][c];
      end
    end
  end
endmodule

// [shared/fsi_pkg.sv]
/*
  fsi_pkg: constants for the fractional sample interpolator.
  Assumes an 8-bit sample store and an 8x8 window whose sample
  at row/column FSI_ORG is the integer position of the request.
*/
package fsi_pkg;
  // window geometry
  localparam int FSI_WIN = 8;
  localparam int FSI_ORG = 3;
  // quarter mode 6-tap filter
  localparam logic signed [9:0] FSI_TAP6 [0:5] = '{
    10'sh001, -10'sh005, 10'sh014, 10'sh014, -10'sh005, 10'sh001};
  // eighth mode 8-tap sets for 1/4, 2/4, 3/4
  localparam logic signed [9:0] FSI_TAP8 [1:3][0:7] = '{
    '{-10'sh003, 10'sh00C, -10'sh025, 10'sh0E5,
      10'sh047, -10'sh015, 10'sh006, -10'sh001},
    '{-10'sh003, 10'sh00C, -10'sh027, 10'sh09E,
      10'sh09E, -10'sh027, 10'sh00C, -10'sh003},
    '{-10'sh001, 10'sh006, -10'sh015, 10'sh047,
      10'sh0E5, -10'sh025, 10'sh00C, -10'sh003}};
  // rounding offsets and shifts
  localparam logic signed [31:0] FSI_RND_Q1 = 32'sh0000_0010;
  localparam int FSI_SH_Q1 = 5;
  localparam logic signed [31:0] FSI_RND_Q2 = 32'sh0000_0200;
  localparam int FSI_SH_Q2 = 10;
  localparam logic signed [31:0] FSI_RND_E1 = 32'sh0000_0080;
  localparam int FSI_SH_E1 = 8;
  localparam logic signed [31:0] FSI_RND_E2 = 32'sh0000_8000;
  localparam int FSI_SH_E2 = 16;
  // chroma scales: s and log2 of s squared
  localparam logic [4:0] FSI_CS_Q = 5'h08;
  localparam int FSI_CSH_Q = 6;
  localparam logic [4:0] FSI_CS_E = 5'h10;
  localparam int FSI_CSH_E = 8;
  // reset values
  localparam logic [7:0] FSI_OUT_RST = 8'h00;
  // luma precision
  typedef enum logic {FSI_QUARTER, FSI_EIGHTH} fsi_prec_type;
endpackage

// [verilog/fsi_interp.sv]
/*
  fsi_interp: one prediction sample per request, luma in quarter or
  eighth precision, or chroma bilinear. Result two cycles after the
  request. Assumes the reference store presents the whole 8x8 window
  with the request, on the same clock, and that the consumer never
  stalls.
*/
// Contract
// - precision select picks 6-tap or 8-tap luma
// - integer positions pass the sample unchanged
// - quarter half uses taps 1,-5,20,20,-5,1
// - quarter half: add 16, shift 5, clamp
// - quarter centre: filter intermediates, add 512, shift 10
// - quarter axis positions average two neighbours, truncating
// - quarter diagonals average nearest half values
// - quarter corner: four integers plus 2, shift 2
// - eighth mode uses three 8-tap sets
// - eighth one-direction: add 128, shift 8, clamp
// - eighth two-direction: add 32768, shift 16, clamp
// - eighth axis positions average two neighbours
// - eighth corner diagonals average quarter values
// - eighth inner diagonals: integer plus three centre
// - eighth offset diagonals: three near plus other
// - chroma is bilinear with rounding by half
// - chroma scale 8 or 16 by precision
`timescale 1ns/1ps
module fsi_interp
  import fsi_pkg::*;
(
  // clock and reset
  input wire logic clock,
  input wire logic srst,
  // request from the reference store
  input wire logic req_valid,
  input wire logic req_eighth,
  input wire logic req_chroma,
  input wire logic [3:0] frac_x,
  input wire logic [3:0] frac_y,
  input wire logic [7:0] ref_win [0:7][0:7],
  // prediction result
  output logic out_valid,
  output logic [7:0] out_sample
);

  // stage one registers
  logic st_valid_reg;
  fsi_prec_type st_prec_reg;
  logic st_chroma_reg;
  logic [3:0] st_fx_reg;
  logic [3:0] st_fy_reg;
  logic [7:0] win_reg [0:7][0:7];
  // output registers and the combinational next sample
  logic out_valid_reg;
  logic [7:0] out_sample_reg;
  logic [7:0] out_sample_next;

  function automatic logic [7:0] clamp_to_sample_range(
    input logic signed [31:0] v);
    if (v < 0) begin
      return 8'h00;
    end
    if (v > 32'sh0000_00FF) begin
      return 8'hFF;
    end
    return v[7:0];
  endfunction

  // round, shift, clamp
  function automatic logic [7:0] fsi_round(input logic signed [31:0] v,
    input logic signed [31:0] add, input int sh);
    return clamp_to_sample_range((v + add) >>> sh);
  endfunction

  function automatic logic [7:0] fsi_avg(input logic [7:0] a,
    input logic [7:0] b);
    logic [8:0] s;
    s = {1'b0, a} + {1'b0, b};
    return s[8:1];
  endfunction

  // 3*a + b + 2 >> 2, always within sample range
  function automatic logic [7:0] fsi_w31(input logic [7:0] a,
    input logic [7:0] b);
    logic [10:0] s;
    s = 11'(3 * a) + {3'h0, b} + 11'h002;
    return s[9:2];
  endfunction

  // six taps over s[1..6], unrounded
  function automatic logic signed [31:0] fsi_fir6(
    input logic signed [31:0] s [0:7]);
    logic signed [31:0] acc;
    acc = '0;
    for (int i = 0; i < 6; i++) begin
      acc = acc + s[i + 1] * 32'(FSI_TAP6[i]);
    end
    return acc;
  endfunction

  function automatic logic signed [31:0] fsi_fir8(
    input logic signed [31:0] s [0:7], input int k);
    logic signed [31:0] acc;
    acc = '0;
    for (int i = 0; i < FSI_WIN; i++) begin
      acc = acc + s[i] * 32'(FSI_TAP8[k][i]);
    end
    return acc;
  endfunction

  // request capture; no back-pressure, one request per cycle
  always_ff @(posedge clock) begin
    if (srst) begin
      st_valid_reg <= 1'b0;
      st_prec_reg <= FSI_QUARTER;
      st_chroma_reg <= 1'b0;
      st_fx_reg <= 4'h0;
      st_fy_reg <= 4'h0;
    end else begin
      st_valid_reg <= req_valid;
      if (req_valid) begin
        st_prec_reg <= fsi_prec_type'(req_eighth);
        st_chroma_reg <= req_chroma;
        st_fx_reg <= frac_x;
        st_fy_reg <= frac_y;
      end
    end
  end

  // window data carries no reset; only qualified by st_valid_reg
  always_ff @(posedge clock) begin
    if (req_valid) begin
      win_reg <= ref_win;
    end
  end

  // widened window and its transpose
  logic signed [31:0] ws [0:7][0:7];
  logic signed [31:0] wt [0:7][0:7];
  // unrounded first and second direction values kept at 32 bits
  logic signed [31:0] h6 [0:7];
  logic signed [31:0] v6 [0:1];
  logic signed [31:0] c6;
  logic signed [31:0] h8 [1:3][0:7];
  logic signed [31:0] v8 [1:3][0:1];
  logic signed [31:0] c8 [1:3][1:3];

  genvar gr, gc, gk;
  generate
    for (gr = 0; gr < FSI_WIN; gr++) begin : g_row
      for (gc = 0; gc < FSI_WIN; gc++) begin : g_col
        assign ws[gr][gc] = {24'h000000, win_reg[gr][gc]};
        assign wt[gc][gr] = {24'h000000, win_reg[gr][gc]};
      end
      assign h6[gr] = fsi_fir6(ws[gr]);
    end
    for (gc = 0; gc < 2; gc++) begin : g_vcol
      assign v6[gc] = fsi_fir6(wt[FSI_ORG + gc]);
    end
    for (gk = 1; gk < 4; gk++) begin : g_set
      for (gr = 0; gr < FSI_WIN; gr++) begin : g_h8
        assign h8[gk][gr] = fsi_fir8(ws[gr], gk);
      end
      for (gc = 0; gc < 2; gc++) begin : g_v8
        assign v8[gk][gc] = fsi_fir8(wt[FSI_ORG + gc], gk);
      end
      for (gc = 1; gc < 4; gc++) begin : g_c8
        assign c8[gk][gc] = fsi_fir8(h8[gk], gc);
      end
    end
  endgenerate

  // centre uses unrounded horizontal intermediates
  assign c6 = fsi_fir6(h6);

  // quarter mode half grid hg[x][y], x,y in half units
  logic [7:0] hg [0:2][0:2];
  always_comb begin
    hg[0][0] = win_reg[FSI_ORG][FSI_ORG];
    hg[2][0] = win_reg[FSI_ORG][FSI_ORG + 1];
    hg[0][2] = win_reg[FSI_ORG + 1][FSI_ORG];
    hg[2][2] = win_reg[FSI_ORG + 1][FSI_ORG + 1];
    hg[1][0] = fsi_round(h6[FSI_ORG], FSI_RND_Q1, FSI_SH_Q1);
    hg[1][2] = fsi_round(h6[FSI_ORG + 1], FSI_RND_Q1, FSI_SH_Q1);
    hg[0][1] = fsi_round(v6[0], FSI_RND_Q1, FSI_SH_Q1);
    hg[2][1] = fsi_round(v6[1], FSI_RND_Q1, FSI_SH_Q1);
    hg[1][1] = fsi_round(c6, FSI_RND_Q2, FSI_SH_Q2);
  end

  // eighth mode quarter grid qg[x][y], x,y in quarter units
  logic [7:0] qg [0:4][0:4];
  always_comb begin
    for (int x = 0; x < 5; x++) begin
      for (int y = 0; y < 5; y++) begin
        if (x % 4 == 0 && y % 4 == 0) begin
          qg[x][y] = win_reg[FSI_ORG + y / 4][FSI_ORG + x / 4];
        end else if (y % 4 == 0) begin
          qg[x][y] = fsi_round(h8[x][FSI_ORG + y / 4], FSI_RND_E1,
            FSI_SH_E1);
        end else if (x % 4 == 0) begin
          qg[x][y] = fsi_round(v8[y][x / 4], FSI_RND_E1,
            FSI_SH_E1);
        end else begin
          qg[x][y] = fsi_round(c8[x][y], FSI_RND_E2, FSI_SH_E2);
        end
      end
    end
  end

  // quarter mode position select
  logic [7:0] lq;
  logic [1:0] qx;
  logic [1:0] qy;
  logic [9:0] qsum;
  always_comb begin
    qx = st_fx_reg[1:0];
    qy = st_fy_reg[1:0];
    qsum = 10'({2'h0, hg[0][0]} + hg[2][0] + hg[0][2] + hg[2][2]) + 10'h002;
    case ({qx[0], qy[0]})
      2'b00: lq = hg[qx >> 1][qy >> 1];
      2'b10: lq = fsi_avg(hg[qx >> 1][qy >> 1],
        hg[(qx >> 1) + 1][qy >> 1]);
      2'b01: lq = fsi_avg(hg[qx >> 1][qy >> 1],
        hg[qx >> 1][(qy >> 1) + 1]);
      default: begin
        if (qx == 2'h3 && qy == 2'h3) begin
          lq = qsum[9:2];
        end else begin
          lq = fsi_avg(hg[1][qy[1] ? 2 : 0], hg[qx[1] ? 2 : 0][1]);
        end
      end
    endcase
  end

  // eighth mode position select
  logic [7:0] le;
  logic [2:0] ex;
  logic [2:0] ey;
  logic [2:0] ix;
  logic [2:0] iy;
  logic [2:0] ox;
  logic [2:0] oy;
  logic xm;
  logic ym;
  always_comb begin
    ex = st_fx_reg[2] ? 3'h4 : 3'h0;
    ey = st_fy_reg[2] ? 3'h4 : 3'h0;
    ix = st_fx_reg[2] ? (st_fx_reg[2:0] >> 1) : (st_fx_reg[2:0] >> 1) + 3'h1;
    iy = st_fy_reg[2] ? (st_fy_reg[2:0] >> 1) : (st_fy_reg[2:0] >> 1) + 3'h1;
    ox = st_fx_reg[2] ? (st_fx_reg[2:0] >> 1) + 3'h1 : (st_fx_reg[2:0] >> 1);
    oy = st_fy_reg[2] ? (st_fy_reg[2:0] >> 1) + 3'h1 : (st_fy_reg[2:0] >> 1);
    xm = st_fx_reg[1] ^ st_fx_reg[2];
    ym = st_fy_reg[1] ^ st_fy_reg[2];
    case ({st_fx_reg[0], st_fy_reg[0]})
      2'b00: le = qg[st_fx_reg[2:1]][st_fy_reg[2:1]];
      2'b10: le = fsi_avg(qg[ix][st_fy_reg[2:1]], qg[ox][st_fy_reg[2:1]]);
      2'b01: le = fsi_avg(qg[st_fx_reg[2:1]][iy], qg[st_fx_reg[2:1]][oy]);
      default: begin
        case ({xm, ym})
          2'b00: le = fsi_avg(qg[ix][ey], qg[ex][iy]);
          2'b11: le = fsi_w31(qg[2][2], qg[ex][ey]);
          2'b10: le = fsi_w31(qg[2][ey], qg[ox][iy]);
          default: le = fsi_w31(qg[ex][2], qg[ix][oy]);
        endcase
      end
    endcase
  end

  // chroma bilinear; weights fit 16 bits, scale picks the shift
  logic [7:0] lc;
  logic [4:0] cs;
  logic [4:0] cdx;
  logic [4:0] cdy;
  logic [31:0] csum;
  always_comb begin
    if (st_prec_reg == FSI_EIGHTH) begin
      cs = FSI_CS_E;
      cdx = {1'b0, st_fx_reg};
      cdy = {1'b0, st_fy_reg};
    end else begin
      cs = FSI_CS_Q;
      cdx = {2'h0, st_fx_reg[2:0]};
      cdy = {2'h0, st_fy_reg[2:0]};
    end
    csum = 32'((cs - cdx) * (cs - cdy) * hg[0][0])
      + 32'(cdx * (cs - cdy) * hg[2][0])
      + 32'((cs - cdx) * cdy * hg[0][2])
      + 32'(cdx * cdy * hg[2][2])
      + 32'(cs * cs / 2);
    if (st_prec_reg == FSI_EIGHTH) begin
      lc = 8'(csum >> FSI_CSH_E);
    end else begin
      lc = 8'(csum >> FSI_CSH_Q);
    end
  end

  // result select
  always_comb begin
    if (st_chroma_reg) begin
      out_sample_next = lc;
    end else if (st_prec_reg == FSI_EIGHTH) begin
      out_sample_next = le;
    end else begin
      out_sample_next = lq;
    end
  end

  // output stage
  always_ff @(posedge clock) begin
    if (srst) begin
      out_valid_reg <= 1'b0;
      out_sample_reg <= FSI_OUT_RST;
    end else begin
      out_valid_reg <= st_valid_reg;
      if (st_valid_reg) begin
        out_sample_reg <= out_sample_next;
      end
    end
  end

  assign out_valid = out_valid_reg;
  assign out_sample = out_sample_reg;

  // helper: every window sample equals the integer sample
  logic st_flat;
  always_comb begin
    st_flat = 1'b1;
    for (int r = 0; r < FSI_WIN; r++) begin
      for (int c = 0; c < FSI_WIN; c++) begin
        if (win_reg[r][c] != win_reg[FSI_ORG][FSI_ORG]) begin
          st_flat = 1'b0;
        end
      end
    end
  end

  sequence s_take;
    req_valid;
  endsequence

  sequence s_deliver;
    ##2 out_valid;
  endsequence

  property p_latency;
    @(posedge clock) disable iff (srst)
    s_take |-> s_deliver;
  endproperty
  a_latency: assert property (p_latency)
    else $error("result not delivered two cycles after request");

  property p_int_pass;
    @(posedge clock) disable iff (srst)
    req_valid && !req_chroma && frac_x == 4'h0 && frac_y == 4'h0
      |-> ##2 out_sample == $past(ref_win[3][3], 2);
  endproperty
  a_int_pass: assert property (p_int_pass)
    else $error("integer position sample altered");

  property p_flat_quarter;
    @(posedge clock) disable iff (srst)
    st_valid_reg && st_flat && !st_chroma_reg && st_prec_reg == FSI_QUARTER
      |=> out_sample == $past(win_reg[3][3]);
  endproperty
  a_flat_quarter: assert property (p_flat_quarter)
    else $error("quarter mode changed a flat area");

  property p_flat_eighth;
    @(posedge clock) disable iff (srst)
    st_valid_reg && st_flat && !st_chroma_reg && st_prec_reg == FSI_EIGHTH
      |=> out_sample == $past(win_reg[3][3]);
  endproperty
  a_flat_eighth: assert property (p_flat_eighth)
    else $error("eighth mode changed a flat area");

  property p_corner;
    @(posedge clock) disable iff (srst)
    st_valid_reg && !st_chroma_reg && st_prec_reg == FSI_QUARTER
      && st_fx_reg[1:0] == 2'h3 && st_fy_reg[1:0] == 2'h3
      |=> out_sample == 8'(($past(10'(win_reg[3][3]) + win_reg[3][4]
        + win_reg[4][3] + win_reg[4][4]) + 10'h002) >> 2);
  endproperty
  a_corner: assert property (p_corner)
    else $error("corner quarter position wrong");

  property p_chroma_half;
    @(posedge clock) disable iff (srst)
    st_valid_reg && st_chroma_reg && st_fy_reg == 4'h0
      && st_fx_reg == (st_prec_reg == FSI_EIGHTH ? 4'h8 : 4'h4)
      |=> out_sample == $past(fsi_avg(win_reg[3][3], win_reg[3][4])
        + 8'((win_reg[3][3][0] | win_reg[3][4][0]) & (win_reg[3][3][0]
        ^ win_reg[3][4][0])));
  endproperty
  a_chroma_half: assert property (p_chroma_half)
    else $error("chroma half weight wrong for scale");

  property p_chroma_int;
    @(posedge clock) disable iff (srst)
    req_valid && req_chroma && frac_x == 4'h0 && frac_y == 4'h0
      |-> ##2 out_valid && out_sample == $past(ref_win[3][3], 2);
  endproperty
  a_chroma_int: assert property (p_chroma_int)
    else $error("chroma integer sample altered");

  property p_clamp_high;
    @(posedge clock) disable iff (srst)
    st_valid_reg && !st_chroma_reg && st_prec_reg == FSI_QUARTER
      && st_fx_reg[1:0] == 2'h2 && st_fy_reg[1:0] == 2'h0
      && win_reg[3][3] == 8'hFF && win_reg[3][4] == 8'hFF
      && win_reg[3][1] == 8'h00 && win_reg[3][2] == 8'h00
      && win_reg[3][5] == 8'h00 && win_reg[3][6] == 8'h00
      |=> out_sample == 8'hFF;
  endproperty
  a_clamp_high: assert property (p_clamp_high)
    else $error("overshoot not clamped to top");

  property p_clamp_low;
    @(posedge clock) disable iff (srst)
    st_valid_reg && !st_chroma_reg && st_prec_reg == FSI_QUARTER
      && st_fx_reg[1:0] == 2'h2 && st_fy_reg[1:0] == 2'h0
      && win_reg[3][3] == 8'h00 && win_reg[3][4] == 8'h00
      && win_reg[3][2] == 8'hFF && win_reg[3][5] == 8'hFF
      && win_reg[3][1] == 8'hFF && win_reg[3][6] == 8'hFF
      |=> out_sample == 8'h00;
  endproperty
  a_clamp_low: assert property (p_clamp_low)
    else $error("undershoot not clamped to zero");

endmodule
